/* core/scr_adc_serial_config_readout.sv */
// Purpose: Serial configuration load, conversion control and result readout.
// Assumes: Serial pins are asynchronous and are oversampled by sys_clk_i.
// Notes:   Output enable of the data pin is active low.
//
// What the document requires
// R1: Results leave as offset binary, midscale 8000.
// R2: Configuration bits sampled on falling serial clock.
// R3: Select falling with clock high starts configuration.
// R4: Select mode loads next eight bits, rise finishes.
// R5: Host idles data input high outside loads.
// R6: Bits 7:6 choose the output interface mode.
// R7: Bits 5:4 choose reference power mode.
// R8: Bit 3 chooses normal or static shutdown.
// R9: Daisy chain treats configuration as shift register.
// R10: Host gives eight edges per chained device.
// R11: New configuration applies from next conversion.
// R12: Power-down shuts down and restores defaults.
// R13: Host waits conversion time without busy indicator.
// R14: Host confines activity to early conversion.
// R15: Host keeps pins quiet around select rise.
// R16: Output bit holds across both clock edges.
// R17: Host idles serial clock low.
// R18: Unread result bits are sent out first.
// R19: Select rise starts conversion, output goes undriven.
// R20: Conversion always runs to its full length.
// R21: Select held low gives MSB at completion.
// R22: Select low shows MSB, falls shift next.
// R23: Output undriven after sixteenth fall or select rise.
// R24: Busy mode drives output low at completion.
// R25: Reserved configuration bits are ignored, kept zero.

`timescale 1ns/1ps

module scr_adc_serial_config_readout (
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        convert_start_select_i,
   input  wire logic        sclk_i,
   input  wire logic        din_i,
   output logic             dout_o,
   output logic             dout_oe_n_o,
   input  wire logic [15:0] sample_data_i,
   input  wire logic        sample_valid_i,
   output logic             sample_ready_o,
   output logic             converting_o,
   output logic [1:0]       out_mode_o,
   output logic [1:0]       ref_mode_o,
   output logic             power_down_bit_o
);

   // ------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ------------------------------------------------------------------
   logic cnv_s1_reg;
   logic cnv_s2_reg;
   logic cnv_d_reg;
   logic sclk_s1_reg;
   logic sclk_s2_reg;
   logic sclk_d_reg;
   logic din_s1_reg;
   logic din_s2_reg;
   logic cnv_rise;
   logic cnv_fall;
   logic sclk_fall;

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         cnv_s1_reg  <= 1'b1;
         cnv_s2_reg  <= 1'b1;
         cnv_d_reg   <= 1'b1;
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sclk_d_reg  <= 1'b0;
         din_s1_reg  <= 1'b1;
         din_s2_reg  <= 1'b1;
      end else begin
         cnv_s1_reg  <= convert_start_select_i;
         cnv_s2_reg  <= cnv_s1_reg;
         cnv_d_reg   <= cnv_s2_reg;
         sclk_s1_reg <= sclk_i;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_d_reg  <= sclk_s2_reg;
         din_s1_reg  <= din_i;
         din_s2_reg  <= din_s1_reg;
      end
   end

   assign cnv_rise  = cnv_s2_reg && !cnv_d_reg;
   assign cnv_fall  = !cnv_s2_reg && cnv_d_reg;
   assign sclk_fall = !sclk_s2_reg && sclk_d_reg;

   // ------------------------------------------------------------------
   // Result FIFO
   // ------------------------------------------------------------------
   logic        fifo_valid;
   logic [15:0] fifo_data;
   logic        conv_done;

   scr_fifo #(
      .W     (scr_pkg::RES_W),
      .DEPTH (scr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .rstn_i      (rstn_i),
      .in_valid_i  (sample_valid_i),
      .in_data_i   (sample_data_i),
      .in_ready_o  (sample_ready_o),
      .out_valid_o (fifo_valid),
      .out_data_o  (fifo_data),
      .out_ready_i (conv_done)
   );

   // ------------------------------------------------------------------
   // Configuration shift path
   // ------------------------------------------------------------------
   logic [7:0] cfg_shift_reg;
   logic [3:0] cfg_cnt_reg;
   logic       cfg_active_reg;
   logic [7:0] active_cfg_reg;
   logic [7:0] pending_cfg_reg;
   logic       pending_valid_reg;
   logic       daisy;
   logic       busy_mode;
   logic       pdn;
   logic       cfg_commit;
   logic       cfg_take_bit;
   logic       conv_start;

   assign daisy        = active_cfg_reg[scr_pkg::MODE_HI];                       // [R6]
   assign busy_mode    = active_cfg_reg[scr_pkg::MODE_LO];                       // [R6]
   assign pdn          = active_cfg_reg[scr_pkg::PDN_BIT];                       // [R8]
   assign cfg_commit   = cfg_active_reg && cnv_rise && (cfg_cnt_reg == scr_pkg::CFG_BITS);
   assign cfg_take_bit = cfg_active_reg && sclk_fall && (daisy || cfg_cnt_reg != scr_pkg::CFG_BITS);

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         cfg_active_reg <= 1'b0;
      end else if (cnv_fall && sclk_s2_reg) begin
         cfg_active_reg <= 1'b1;                                                 // [R3]
      end else if (cnv_rise) begin
         cfg_active_reg <= 1'b0;                                                 // [R4]
      end
   end

   // Daisy mode keeps shifting so that older bits flow on to the next device.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         cfg_shift_reg <= scr_pkg::CFG_RESET;
         cfg_cnt_reg   <= '0;
      end else if (cnv_fall && sclk_s2_reg) begin
         cfg_cnt_reg   <= '0;
      end else if (cfg_take_bit) begin
         cfg_shift_reg <= {cfg_shift_reg[6:0], din_s2_reg};                      // [R2] [R9]
         if (cfg_cnt_reg != scr_pkg::CFG_BITS) begin
            cfg_cnt_reg <= cfg_cnt_reg + 4'h1;                                   // [R4]
         end
      end
   end

   // A power-down byte acts at once; leaving shutdown also acts at once,
   // since no conversion can run to pick the byte up.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         active_cfg_reg    <= scr_pkg::CFG_RESET;
         pending_cfg_reg   <= scr_pkg::CFG_RESET;
         pending_valid_reg <= 1'b0;
      end else if (cfg_commit) begin
         if (cfg_shift_reg[scr_pkg::PDN_BIT]) begin
            active_cfg_reg    <= scr_pkg::CFG_SHUTDOWN;                          // [R12]
            pending_valid_reg <= 1'b0;
         end else if (pdn) begin
            active_cfg_reg    <= cfg_shift_reg & scr_pkg::CFG_RSVD_MASK;         // [R25]
            pending_valid_reg <= 1'b0;
         end else begin
            pending_cfg_reg   <= cfg_shift_reg & scr_pkg::CFG_RSVD_MASK;         // [R25]
            pending_valid_reg <= 1'b1;
         end
      end else if (conv_start && pending_valid_reg) begin
         active_cfg_reg    <= pending_cfg_reg;                                   // [R11]
         pending_valid_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         out_mode_o       <= scr_pkg::MODE_SEL_NOBUSY;
         ref_mode_o       <= 2'h0;
         power_down_bit_o <= 1'b0;
      end else begin
         out_mode_o       <= active_cfg_reg[scr_pkg::MODE_HI:scr_pkg::MODE_LO];  // [R6]
         ref_mode_o       <= active_cfg_reg[scr_pkg::REF_HI:scr_pkg::REF_LO];    // [R7]
         power_down_bit_o <= pdn;                                                // [R8]
      end
   end

   // ------------------------------------------------------------------
   // Conversion control
   // ------------------------------------------------------------------
   scr_pkg::scr_state_t state_reg;
   logic [7:0]          conv_cnt_reg;

   assign conv_start = (state_reg == scr_pkg::ST_ACQ) && cnv_rise && !cfg_active_reg && !pdn;
   assign conv_done  = (state_reg == scr_pkg::ST_CONV) && (conv_cnt_reg == scr_pkg::CONV_LAST)
                       && fifo_valid;

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         state_reg    <= scr_pkg::ST_ACQ;
         conv_cnt_reg <= '0;
         converting_o <= 1'b0;
      end else begin
         case (state_reg)
            scr_pkg::ST_ACQ: begin
               if (conv_start) begin
                  state_reg    <= scr_pkg::ST_CONV;                              // [R19]
                  conv_cnt_reg <= '0;
                  converting_o <= 1'b1;
               end
            end
            scr_pkg::ST_CONV: begin
               if (conv_done) begin
                  state_reg    <= scr_pkg::ST_ACQ;                               // [R20]
                  converting_o <= 1'b0;
               end else if (conv_cnt_reg != scr_pkg::CONV_LAST) begin
                  conv_cnt_reg <= conv_cnt_reg + 8'h01;                          // [R20]
               end
            end
            default: begin
               state_reg    <= scr_pkg::ST_ACQ;
               converting_o <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Readout shift register
   // ------------------------------------------------------------------
   logic [15:0] rd_shift_reg;
   logic [4:0]  rd_left_reg;
   logic        busy_lead_reg;
   logic        rd_driving;
   logic        rd_shift_now;

   assign rd_driving   = !dout_oe_n_o && !cfg_active_reg;
   assign rd_shift_now = rd_driving && sclk_fall && (state_reg == scr_pkg::ST_ACQ);

   // A new result is only accepted once the previous one has been fully read.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || pdn) begin
         rd_shift_reg  <= '0;                                                    // [R12]
         rd_left_reg   <= '0;
         busy_lead_reg <= 1'b0;
      end else if (conv_done) begin
         if (rd_left_reg == '0) begin
            rd_shift_reg  <= {~fifo_data[15], fifo_data[14:0]};                  // [R1]
            rd_left_reg   <= scr_pkg::RD_BITS;
            busy_lead_reg <= busy_mode;                                          // [R24]
         end
      end else if (rd_shift_now) begin
         if (busy_lead_reg) begin
            busy_lead_reg <= 1'b0;
         end else begin
            rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};                          // [R22] [R18]
            rd_left_reg  <= rd_left_reg - 5'h01;                                 // [R23]
         end
      end
   end

   // ------------------------------------------------------------------
   // Data pin drive
   // ------------------------------------------------------------------
   // The pin only changes after a falling clock edge, so a bit is stable
   // across the rising edge that follows and the falling edge that ends it.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         dout_o      <= 1'b0;
         dout_oe_n_o <= 1'b1;
      end else if (cnv_rise) begin
         dout_oe_n_o <= 1'b1;                                                    // [R19] [R23]
      end else if (cfg_active_reg && daisy) begin
         dout_o      <= cfg_shift_reg[7];                                        // [R9]
         dout_oe_n_o <= 1'b0;
      end else if (state_reg == scr_pkg::ST_ACQ && !cnv_s2_reg && !cfg_active_reg
                   && rd_left_reg != '0) begin
         dout_o      <= busy_lead_reg ? 1'b0 : rd_shift_reg[15];                 // [R16] [R21] [R24]
         dout_oe_n_o <= 1'b0;                                                    // [R22]
      end else begin
         dout_oe_n_o <= 1'b1;                                                    // [R23]
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_offset_binary: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R1]
      (conv_done && rd_left_reg == '0 && !pdn) |=>
         (rd_shift_reg == {~$past(fifo_data[15]), $past(fifo_data[14:0])}))
      else $error("result not in offset binary");

   a_cfg_entry: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R3]
      (cnv_fall && sclk_s2_reg) |=> cfg_active_reg)
      else $error("configuration write not entered");

   a_din_sample: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R2]
      (cfg_take_bit && !cnv_fall) |=> (cfg_shift_reg[0] == $past(din_s2_reg)))
      else $error("data input not sampled on falling clock");

   a_cfg_count: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R4]
      (cfg_active_reg && !daisy && cfg_cnt_reg == scr_pkg::CFG_BITS && sclk_fall && !cnv_fall)
         |=> $stable(cfg_shift_reg))
      else $error("select mode took more than eight bits");

   a_rsvd_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R25]
      $rose(pending_valid_reg) |-> (pending_cfg_reg[2:0] == 3'h0 && active_cfg_reg[2:0] == 3'h0))
      else $error("reserved bits stored");

   a_start_hiz: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R19]
      conv_start |=> (dout_oe_n_o && converting_o && state_reg == scr_pkg::ST_CONV))
      else $error("conversion start did not release output");

   a_conv_length: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R20]
      $fell(converting_o) |-> ($past(conv_cnt_reg) == scr_pkg::CONV_LAST))
      else $error("conversion ended early");

   a_stop_after_16: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R23]
      (rd_shift_now && !busy_lead_reg && rd_left_reg == 5'h01 && !conv_done) |-> ##2 dout_oe_n_o)
      else $error("output still driven after last bit");

   a_busy_low: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R24]
      (conv_done && busy_mode && !daisy && !pdn && rd_left_reg == '0 && !cnv_s2_reg
         && !cfg_active_reg) ##1 (!cnv_rise && !cnv_s2_reg) |-> ##1 (!dout_oe_n_o && !dout_o))
      else $error("busy indicator not driven low");

   a_pend_apply: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R11]
      (conv_start && pending_valid_reg) |=> (active_cfg_reg == $past(pending_cfg_reg)))
      else $error("pending configuration not applied at conversion start");

   a_pdn_default: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R12]
      (cfg_commit && cfg_shift_reg[scr_pkg::PDN_BIT]) |=> ##1
         (active_cfg_reg == scr_pkg::CFG_SHUTDOWN && rd_left_reg == '0 && !pending_valid_reg))
      else $error("shutdown did not restore defaults");

endmodule

/* core/scr_fifo.sv */
// Purpose: Result FIFO between the converter core and the serial readout.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Ready and valid are registered; ready falls when full.

`timescale 1ns/1ps

module scr_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   input  wire logic         sys_clk_i,
   input  wire logic         rstn_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic          push;
   logic          pop;

   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_ready_i && out_valid_o;
   assign out_data_o  = mem[rd_ptr_reg];

   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + CW'(1);
      end else if (pop && !push) begin
         count_next = count_reg - CW'(1);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         wr_ptr_reg  <= '0;
         rd_ptr_reg  <= '0;
         count_reg   <= '0;
         in_ready_o  <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
         end
         count_reg   <= count_next;
         in_ready_o  <= (count_next != CW'(DEPTH));
         out_valid_o <= (count_next != '0);
      end
   end

endmodule

/* core/scr_pkg.sv */
// Purpose: Shared constants of the serial configuration and readout block.
// Assumes: Core clock of 100 MHz; serial pins sampled by that clock.
// Notes:   Configuration field positions and reset values, modes and counts live here.

package scr_pkg;

   // ------------------------------------------------------------------
   // Configuration byte layout
   // ------------------------------------------------------------------
   localparam int         CFG_W          = 8;
   localparam int         MODE_HI        = 7;
   localparam int         MODE_LO        = 6;
   localparam int         REF_HI         = 5;
   localparam int         REF_LO         = 4;
   localparam int         PDN_BIT        = 3;
   localparam logic [7:0] CFG_RESET      = 8'h00;
   localparam logic [7:0] CFG_RSVD_MASK  = 8'hF8;
   localparam logic [7:0] CFG_SHUTDOWN   = 8'h08;
   localparam logic [3:0] CFG_BITS       = 4'h8;

   // ------------------------------------------------------------------
   // Output interface modes
   // ------------------------------------------------------------------
   localparam logic [1:0] MODE_SEL_NOBUSY = 2'h0;
   localparam logic [1:0] MODE_SEL_BUSY   = 2'h1;
   localparam logic [1:0] MODE_DC_NOBUSY  = 2'h2;
   localparam logic [1:0] MODE_DC_BUSY    = 2'h3;

   // ------------------------------------------------------------------
   // Result and timing
   // ------------------------------------------------------------------
   localparam int         RES_W          = 16;
   localparam logic [4:0] RD_BITS        = 5'h10;
   localparam int         FIFO_DEPTH     = 16;
   localparam int         SCLK_MAX_MHZ   = 50;
   localparam int         CLK_MHZ        = 100;
   localparam int         CONV_TIME_NS   = 2000;
   localparam int         CONV_CNT_W     = 8;
   localparam logic [7:0] CONV_CYCLES    = 8'((CONV_TIME_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] CONV_LAST      = CONV_CYCLES - 8'h01;

   typedef enum logic {
      ST_ACQ,
      ST_CONV
   } scr_state_t;

endpackage

/* tb/scr_adc_serial_config_readout_bench.sv */
// Purpose: Self-checking bench for the serial configuration and readout block.
// Assumes: 100 MHz core clock; the host model supplies all serial input pins.
// Notes:   Result words are pushed by the bench in place of the converter core.

`timescale 1ns/1ps

module scr_adc_serial_config_readout_bench;
   logic        sys_clk      = 1'b0;
   logic        rstn         = 1'b0;
   logic [15:0] sample_data  = 16'h0000;
   logic        sample_valid = 1'b0;
   wire         select;
   wire         sclk;
   wire         din;
   wire         dout;
   wire         dout_oe_n;
   wire         sample_ready;
   wire         converting;
   wire         pdn;
   wire  [1:0]  out_mode;
   wire  [1:0]  ref_mode;
   int          mismatches   = 0;
   int          check_count  = 0;
   int          cycles       = 0;

   always #5 sys_clk = ~sys_clk;

   scr_adc_serial_config_readout DUT (
      .sys_clk_i              (sys_clk),
      .rstn_i                 (rstn),
      .convert_start_select_i (select),
      .sclk_i                 (sclk),
      .din_i                  (din),
      .dout_o                 (dout),
      .dout_oe_n_o            (dout_oe_n),
      .sample_data_i          (sample_data),
      .sample_valid_i         (sample_valid),
      .sample_ready_o         (sample_ready),
      .converting_o           (converting),
      .out_mode_o             (out_mode),
      .ref_mode_o             (ref_mode),
      .power_down_bit_o       (pdn)
   );

   scr_host_model host (
      .select_o    (select),
      .sclk_o      (sclk),
      .din_o       (din),
      .dout_i      (dout),
      .dout_oe_n_i (dout_oe_n)
   );

   // ------------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic push(input logic [15:0] d);
      @(negedge sys_clk);
      sample_data = d;
      sample_valid = 1'b1;
      @(posedge sys_clk);
      while (sample_ready !== 1'b1) @(posedge sys_clk);
      @(negedge sys_clk);
      sample_valid = 1'b0;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 10000) begin
         mismatches++;
         conclude();
      end
   end

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic check_reset();
      chk(16'(dout_oe_n), 16'h0001, "pin released after reset");
      chk(16'(converting), 16'h0000, "idle after reset");
      chk(16'(out_mode), 16'h0000, "default mode");
      chk(16'(ref_mode), 16'h0000, "default reference");
      chk(16'(pdn), 16'h0000, "default power state");
      chk(16'(sample_ready), 16'h0001, "result buffer ready after reset");
   endtask

   // Each byte written during a conversion becomes active at the next one.
   task automatic modes_and_codes();
      logic [7:0]  cfg [4] = '{8'h77, 8'h90, 8'hE0, 8'h00};
      logic [15:0] d [4]   = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};
      logic [15:0] e [4]   = '{16'h8000, 16'hFFFF, 16'h0000, 16'h7FFF};
      logic [7:0]  act;
      logic [16:0] bits;
      for (int m = 0; m < 4; m++) begin
         act = (m == 0) ? 8'h00 : cfg[m-1];
         push(d[m]);
         host.cycle(1'b1, cfg[m], m < 2);
         chk(16'(converting), 16'h0001, "busy through select toggles");
         #1000;
         chk(16'(converting), 16'h0000, "conversion ended");
         chk(16'(out_mode), 16'(act[7:6]), "interface mode");
         chk(16'(ref_mode), 16'(act[5:4]), "reference mode");
         if (m < 3) begin
            chk(16'(dout_oe_n), 16'h0000, "pin driven at end");
            chk(16'(dout), (act[7:6] == 2'h1) ? 16'h0000 : 16'(e[m][15]), "first level");
            host.read_bits((act[7:6] == 2'h1) ? 17 : 16, bits);
            chk(bits[15:0], e[m], "result code");
            chk(16'(dout_oe_n), 16'h0001, "pin released after last bit");
         end
      end
   endtask

   task automatic shutdown_restores();
      push(16'h1234);
      host.cycle(1'b1, 8'h48, 1'b0);
      #200;
      chk(16'(pdn), 16'h0001, "shut down");
      chk(16'(out_mode), 16'h0000, "mode back to default");
      chk(16'(ref_mode), 16'h0000, "reference back to default");
      #1000;
      host.cycle(1'b0, 8'h00, 1'b0);
      chk(16'(converting), 16'h0000, "no conversion while shut down");
      host.cycle(1'b1, 8'h00, 1'b0);
      #200;
      chk(16'(pdn), 16'h0000, "woken");
   endtask

   task automatic partial_read();
      logic [16:0] bits;
      push(16'h1234);
      host.cycle(1'b0, 8'h00, 1'b0);
      #1000;
      host.read_bits(5, bits);
      chk(bits[15:0], 16'h0012, "first five bits");
      push(16'h5555);
      host.cycle(1'b0, 8'h00, 1'b0);
      chk(16'(dout_oe_n), 16'h0001, "released by select rise");
      #1000;
      host.read_bits(11, bits);
      chk(bits[15:0], 16'h0234, "leftover bits first");
      chk(16'(dout_oe_n), 16'h0001, "released when bits run out");
   endtask

   initial begin
      repeat (10) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (4) @(negedge sys_clk);
      check_reset();
      modes_and_codes();
      shutdown_restores();
      partial_read();
      conclude();
   end
endmodule

/* tb/scr_host_model.sv */
// Purpose: Behavioural serial host that loads configuration bytes, starts conversions and reads results.
// Assumes: Serial clock period of 125 ns, unrelated in phase to the core clock.
// Notes:   The data line has a pull-up, so a released pin reads as one.

`timescale 1ns/1ps

module scr_host_model (
   output logic      select_o,
   output logic      sclk_o,
   output logic      din_o,
   input  wire logic dout_i,
   input  wire logic dout_oe_n_i
);
   localparam realtime HALF = 62.5;

   wire pin_level = dout_oe_n_i ? 1'b1 : dout_i;

   initial begin
      select_o = 1'b1;
      sclk_o = 1'b0;
      din_o = 1'b1;
   end

   // ------------------------------------------------------------------
   // Conversion start, optionally with a configuration load inside it
   // ------------------------------------------------------------------
   // Without the extra edge both branches take the same time, so the caller can count on it.
   // The extra edge is a ninth falling clock in select mode, which the block must ignore.
   task automatic cycle(input logic cfg_en, input logic [7:0] b, input logic extra);
      select_o = 1'b0;
      #(2*HALF) select_o = 1'b1;
      #(2*HALF);
      if (cfg_en) begin
         sclk_o = 1'b1;
         #HALF select_o = 1'b0;
         #HALF;
         for (int i = 7; i >= 0; i--) begin
            din_o = b[i];
            #HALF sclk_o = 1'b0;
            #HALF sclk_o = 1'b1;
         end
         if (extra) begin
            din_o = ~b[0];
            #HALF sclk_o = 1'b0;
            #HALF sclk_o = 1'b1;
         end
         #HALF select_o = 1'b1;
         #HALF sclk_o = 1'b0;
         din_o = 1'b1;
      end else begin
         #300 select_o = 1'b0;
         #300 select_o = 1'b1;
         #650;
      end
      #HALF select_o = 1'b0;
   endtask

   // ------------------------------------------------------------------
   // Readout, first bit taken before any falling edge
   // ------------------------------------------------------------------
   task automatic read_bits(input int n, output logic [16:0] bits);
      bits = '0;
      select_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         #HALF sclk_o = 1'b1;
         #HALF bits = {bits[15:0], pin_level};
         sclk_o = 1'b0;
      end
      #(2*HALF);
   endtask
endmodule
